/* common/eeprom_ctl_pkg.sv */
// Constants for the serial EEPROM power-up and write-state control
package eeprom_ctl_pkg;

  // Instruction codes
  localparam logic [7:0] CMD_WRSTAT    = 8'h01;
  localparam logic [7:0] CMD_WRITE     = 8'h02;
  localparam logic [7:0] CMD_READ      = 8'h03;
  localparam logic [7:0] CMD_WRDIS     = 8'h04;
  localparam logic [7:0] CMD_STATREAD  = 8'h05;
  localparam logic [7:0] CMD_WRENA     = 8'h06;

  // Status register bit positions
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_LATCH_POS = 1;

  // Address is 16 bits after the opcode
  localparam logic [5:0] ADDR_BITS     = 6'h10;
  localparam logic [5:0] OPC_BITS      = 6'h08;

  // Self-timed write cycle
  localparam int WRITE_TIME_US = 5;
  localparam int CLK_MHZ       = 50;
  localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
  localparam int WCNT_W        = 9;

  // Power-on reset hold
  localparam logic [3:0] POR_CYCLES = 4'h8;

  // Reset values
  localparam logic       WEL_RST   = 1'b0;
  localparam logic [7:0] STAT_RST  = 8'h00;

  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_STANDBY = 3'b001,
    ST_READY   = 3'b010,
    ST_BUSY    = 3'b011
  } pwr_state_t;

  typedef enum logic [2:0] {
    SH_OPC    = 3'b000,
    SH_ADDR   = 3'b001,
    SH_DATA   = 3'b010,
    SH_STATO  = 3'b011,
    SH_IGNORE = 3'b100
  } shift_state_t;

endpackage : eeprom_ctl_pkg

/* logic/pin_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pin_sync
  import eeprom_ctl_pkg::*;
#(
  parameter int W = 4
)(
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  // Pins
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;

endmodule : pin_sync

/* logic/eeprom_write_state.sv */
// Power-up, write-enable and self-timed write control of an SPI EEPROM
// Behaviour
// - Supply good enters standby, logic initialised
// - Supply loss enters reset state
// - Powers up write-disabled, latch clear, standby
// - Chip select low enters ready state
// - Successful write returns to write-disabled
// - Chip select rise starts self-timed write
// - Array access ignored while programming
// - Unknown opcode ignored, output stays floating
// - Write enable sets latch at deselect
// - Write disable clears the latch
// - Busy ignores all but status read
// - Busy status bit high during write
`timescale 1ns/1ns
module eeprom_write_state
  import eeprom_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Supply monitor
  input  wire logic        i_supply_ok,
  // SPI pins
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_si,
  output logic             o_so,
  output logic             o_so_oe,
  // Array write request
  output logic             o_prog_start,
  output logic [15:0]      o_prog_addr,
  output logic [7:0]       o_prog_data,
  // State view
  output logic             o_write_enable_latch,
  output logic             o_busy,
  output logic             o_standby,
  output logic             o_ready
);

  logic [3:0] pins_sync;
  logic       cs_n_s;
  logic       sck_s;
  logic       si_s;
  logic       sup_s;

  pin_sync #(.W(4)) u_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_async ({i_supply_ok, i_cs_n, i_sck, i_si}),
    .o_sync  (pins_sync)
  );

  assign sup_s  = pins_sync[3];
  assign cs_n_s = pins_sync[2];
  assign sck_s  = pins_sync[1];
  assign si_s   = pins_sync[0];

  pwr_state_t   st_r,      st_nxt;
  shift_state_t sh_r,      sh_nxt;
  logic         cs_d_r,    cs_d_nxt;
  logic         sck_d_r,   sck_d_nxt;
  logic [3:0]   por_r,     por_nxt;
  logic         wel_r,     wel_nxt;
  logic [7:0]   sreg_r,    sreg_nxt;
  logic [5:0]   bcnt_r,    bcnt_nxt;
  logic [7:0]   opc_r,     opc_nxt;
  logic [15:0]  addr_r,    addr_nxt;
  logic [7:0]   data_r,    data_nxt;
  logic         dvalid_r,  dvalid_nxt;
  logic [WCNT_W-1:0] wcnt_r, wcnt_nxt;
  logic         so_r,      so_nxt;
  logic         oe_r,      oe_nxt;
  logic         start_r,   start_nxt;
  logic [7:0]   stat_sh_r, stat_sh_nxt;

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] sh_in;

  assign cs_fall  = cs_d_r & ~cs_n_s;
  assign cs_rise  = ~cs_d_r & cs_n_s;
  assign sck_rise = ~sck_d_r & sck_s & ~cs_n_s;
  assign sck_fall = sck_d_r & ~sck_s & ~cs_n_s;
  assign sh_in    = {opc_r[6:0], si_s};

  always_comb
  begin
    st_nxt      = st_r;
    sh_nxt      = sh_r;
    cs_d_nxt    = cs_n_s;
    sck_d_nxt   = sck_s;
    por_nxt     = por_r;
    wel_nxt     = wel_r;
    sreg_nxt    = sreg_r;
    bcnt_nxt    = bcnt_r;
    opc_nxt     = opc_r;
    addr_nxt    = addr_r;
    data_nxt    = data_r;
    dvalid_nxt  = dvalid_r;
    wcnt_nxt    = wcnt_r;
    so_nxt      = so_r;
    oe_nxt      = oe_r;
    start_nxt   = 1'b0;
    stat_sh_nxt = stat_sh_r;
    if (!sup_s)
    begin
      st_nxt     = ST_RESET;
      por_nxt    = 4'h0;
      wel_nxt    = WEL_RST;
      oe_nxt     = 1'b0;
      dvalid_nxt = 1'b0;
      sh_nxt     = SH_OPC;
    end
    else
    begin
      case (st_r)
        ST_RESET:
        begin
          if (por_r == POR_CYCLES)
          begin
            st_nxt  = ST_STANDBY;
            wel_nxt = WEL_RST;
          end
          else
          begin
            por_nxt = por_r + 4'h1;
          end
        end
        ST_STANDBY:
        begin
          if (cs_fall)
          begin
            st_nxt     = ST_READY;
            sh_nxt     = SH_OPC;
            bcnt_nxt   = 6'h00;
            dvalid_nxt = 1'b0;
          end
        end
        ST_READY:
        begin
          if (cs_rise)
          begin
            oe_nxt = 1'b0;
            st_nxt = ST_STANDBY;
            if (sh_r == SH_OPC && bcnt_r == OPC_BITS)
            begin
              if (opc_r == CMD_WRENA)
                wel_nxt = 1'b1;
              else if (opc_r == CMD_WRDIS)
                wel_nxt = 1'b0;
            end
            else if (sh_r == SH_DATA && bcnt_r == 6'h00 && dvalid_r && wel_r)
            begin
              st_nxt    = ST_BUSY;
              start_nxt = (opc_r == CMD_WRITE);
              wcnt_nxt  = WCNT_W'(WRITE_CYCLES);
              if (opc_r == CMD_WRSTAT)
                sreg_nxt = data_r;
            end
          end
          else if (sck_rise)
          begin
            case (sh_r)
              SH_OPC:
              begin
                opc_nxt  = sh_in;
                bcnt_nxt = bcnt_r + 6'h01;
                if (bcnt_r == OPC_BITS - 6'h01)
                begin
                  bcnt_nxt = 6'h00;
                  if (sh_in == CMD_WRITE || sh_in == CMD_READ)
                    sh_nxt = SH_ADDR;
                  else if (sh_in == CMD_WRSTAT)
                    sh_nxt = SH_DATA;
                  else if (sh_in == CMD_STATREAD)
                  begin
                    sh_nxt      = SH_STATO;
                    stat_sh_nxt = {sreg_r[7:2], wel_r, 1'b0};
                  end
                  else if (sh_in == CMD_WRENA || sh_in == CMD_WRDIS)
                    bcnt_nxt = OPC_BITS;
                  else
                    sh_nxt = SH_IGNORE;
                end
              end
              SH_ADDR:
              begin
                addr_nxt = {addr_r[14:0], si_s};
                bcnt_nxt = bcnt_r + 6'h01;
                if (bcnt_r == ADDR_BITS - 6'h01)
                begin
                  bcnt_nxt = 6'h00;
                  sh_nxt   = (opc_r == CMD_WRITE) ? SH_DATA : SH_IGNORE;
                end
              end
              SH_DATA:
              begin
                data_nxt = {data_r[6:0], si_s};
                bcnt_nxt = (bcnt_r == OPC_BITS - 6'h01) ? 6'h00 : bcnt_r + 6'h01;
                if (bcnt_r == OPC_BITS - 6'h01)
                  dvalid_nxt = 1'b1;
              end
              default:
              begin
                bcnt_nxt = bcnt_r;
              end
            endcase
          end
          else if (sck_fall && sh_r == SH_STATO)
          begin
            oe_nxt      = 1'b1;
            so_nxt      = stat_sh_r[7];
            stat_sh_nxt = {stat_sh_r[6:0], stat_sh_r[7]};
          end
        end
        ST_BUSY:
        begin
          if (wcnt_r == '0)
          begin
            st_nxt  = cs_n_s ? ST_STANDBY : ST_BUSY;
            wel_nxt = 1'b0;
          end
          else
          begin
            wcnt_nxt = wcnt_r - WCNT_W'(1);
          end
          if (cs_fall)
          begin
            sh_nxt   = SH_OPC;
            bcnt_nxt = 6'h00;
            oe_nxt   = 1'b0;
          end
          if (cs_rise)
            oe_nxt = 1'b0;
          else if (sck_rise && sh_r == SH_OPC)
          begin
            opc_nxt  = sh_in;
            bcnt_nxt = bcnt_r + 6'h01;
            if (bcnt_r == OPC_BITS - 6'h01)
            begin
              bcnt_nxt    = 6'h00;
              sh_nxt      = (sh_in == CMD_STATREAD) ? SH_STATO : SH_IGNORE;
              stat_sh_nxt = {sreg_r[7:2], wel_r, 1'b1};
            end
          end
          else if (sck_fall && sh_r == SH_STATO)
          begin
            oe_nxt      = 1'b1;
            so_nxt      = stat_sh_r[7];
            stat_sh_nxt = {stat_sh_r[6:0], stat_sh_r[7]};
          end
        end
        default:
        begin
          st_nxt = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      st_r      <= ST_RESET;
      sh_r      <= SH_OPC;
      cs_d_r    <= 1'b1;
      sck_d_r   <= 1'b0;
      por_r     <= 4'h0;
      wel_r     <= WEL_RST;
      sreg_r    <= STAT_RST;
      bcnt_r    <= 6'h00;
      opc_r     <= 8'h00;
      addr_r    <= 16'h0000;
      data_r    <= 8'h00;
      dvalid_r  <= 1'b0;
      wcnt_r    <= '0;
      so_r      <= 1'b0;
      oe_r      <= 1'b0;
      start_r   <= 1'b0;
      stat_sh_r <= 8'h00;
    end
    else
    begin
      st_r      <= st_nxt;
      sh_r      <= sh_nxt;
      cs_d_r    <= cs_d_nxt;
      sck_d_r   <= sck_d_nxt;
      por_r     <= por_nxt;
      wel_r     <= wel_nxt;
      sreg_r    <= sreg_nxt;
      bcnt_r    <= bcnt_nxt;
      opc_r     <= opc_nxt;
      addr_r    <= addr_nxt;
      data_r    <= data_nxt;
      dvalid_r  <= dvalid_nxt;
      wcnt_r    <= wcnt_nxt;
      so_r      <= so_nxt;
      oe_r      <= oe_nxt;
      start_r   <= start_nxt;
      stat_sh_r <= stat_sh_nxt;
    end
  end

  assign o_so                 = so_r;
  assign o_so_oe              = oe_r & ~cs_n_s;
  assign o_prog_start         = start_r;
  assign o_prog_addr          = addr_r;
  assign o_prog_data          = data_r;
  assign o_write_enable_latch = wel_r;
  assign o_busy               = (st_r == ST_BUSY);
  assign o_standby            = (st_r == ST_STANDBY);
  assign o_ready              = (st_r == ST_READY);

endmodule : eeprom_write_state

/* bench/spi_host_model.sv */
// Host SPI controller model, mode 0, clock idle low
`timescale 1ns/1ns
module spi_host_model (
  // Clock
  input  wire logic i_mclk,
  // SPI pins
  output logic      o_cs_n = 1'b1,
  output logic      o_sck  = 1'b0,
  output logic      o_si   = 1'b0,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  task automatic xfer(input logic [31:0] d, input int n,
                      output logic [7:0] rx, output logic oe);
    rx = 8'h00;
    oe = 1'b0;
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_si <= d[i];
      repeat (4) @(posedge i_mclk);
      o_sck <= 1'b1;
      repeat (4) @(posedge i_mclk);
      rx = {rx[6:0], i_so};
      oe = oe | i_so_oe;
      o_sck <= 1'b0;
    end
    repeat (4) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    o_si   <= ~o_si;
    repeat (6) @(posedge i_mclk);
  endtask : xfer
endmodule : spi_host_model

/* bench/eeprom_write_state_monitor.sv */
// Assertion checker for the EEPROM write-state control
`timescale 1ns/1ns
module eeprom_write_state_monitor (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_supply_ok,
  input wire logic i_cs_n,
  input wire logic o_so_oe,
  input wire logic o_prog_start,
  input wire logic o_write_enable_latch,
  input wire logic o_busy,
  input wire logic o_standby,
  input wire logic o_ready
);
  logic [8:0] bcnt_r;
  logic [8:0] bcnt_nxt;
  always_comb
  begin
    bcnt_nxt = o_busy ? bcnt_r + 9'h001 : 9'h000;
  end
  always_ff @(posedge i_mclk)
  begin
    bcnt_r <= i_rst ? 9'h000 : bcnt_nxt;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_one_state;
    $onehot0({o_busy, o_standby, o_ready});
  endproperty
  a_one_state: assert property (p_one_state) else $error("two states at once");
  property p_power_loss;
    !i_supply_ok [*4] |-> !o_write_enable_latch && !o_standby && !o_ready && !o_busy;
  endproperty
  a_power_loss: assert property (p_power_loss) else $error("no reset on supply loss");
  property p_ready;
    $fell(i_cs_n) && o_standby |-> ##4 o_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("select did not make ready");
  property p_start_busy;
    o_prog_start |-> ##[0:1] o_busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("write start without busy");
  property p_start_latch;
    o_prog_start |-> $past(o_write_enable_latch);
  endproperty
  a_start_latch: assert property (p_start_latch) else $error("write without latch");
  property p_no_start_busy;
    o_busy && $past(o_busy) |-> !o_prog_start;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("start while busy");
  property p_busy_len;
    $fell(o_busy) |-> bcnt_r >= 9'h0FB;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too short");
  property p_latch_clear;
    $fell(o_busy) |-> ##[0:1] !o_write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch kept after write");
  property p_oe_idle;
    i_cs_n [*3] |-> !o_so_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven unselected");
endmodule : eeprom_write_state_monitor
bind eeprom_write_state eeprom_write_state_monitor i_mon (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_supply_ok(i_supply_ok), .i_cs_n(i_cs_n),
  .o_so_oe(o_so_oe), .o_prog_start(o_prog_start),
  .o_write_enable_latch(o_write_enable_latch), .o_busy(o_busy),
  .o_standby(o_standby), .o_ready(o_ready));

/* bench/test_eeprom_write_state.sv */
// Self-checking bench for the EEPROM write-state control
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module test_eeprom_write_state;
  import eeprom_ctl_pkg::*;
  typedef struct packed { logic [31:0] d; logic [5:0] n; logic write_enable_latch; } row_t;
  logic        i_mclk      = 1'b0;
  logic        i_rst       = 1'b1;
  logic        i_supply_ok = 1'b1;
  logic        cs_n, sck, si, so, so_oe, start, write_enable_latch, busy, stby, rdy, oe;
  logic [15:0] addr;
  logic [7:0]  data, rx;
  int          fail_count   = 0;
  int          total_checks = 0;
  int          starts       = 0;
  int          i;
  row_t        rows [8] = '{'{32'h06, 6'h08, 1'b1}, '{32'h04, 6'h08, 1'b0},
    '{32'h01FC, 6'h10, 1'b0}, '{32'h06, 6'h08, 1'b1}, '{32'hFF, 6'h08, 1'b1},
    '{32'h08, 6'h09, 1'b1}, '{32'h04, 6'h08, 1'b0}, '{32'h0200005A, 6'h20, 1'b0}};
  always #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (start === 1'b1) starts++;
  spi_host_model i_host (.i_mclk(i_mclk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si),
    .i_so(so), .i_so_oe(so_oe));
  eeprom_write_state i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_supply_ok(i_supply_ok),
    .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe),
    .o_prog_start(start), .o_prog_addr(addr), .o_prog_data(data),
    .o_write_enable_latch(write_enable_latch), .o_busy(busy), .o_standby(stby), .o_ready(rdy));
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    summarize();
  end
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (i = 0; i < 40 && stby !== 1'b1; i++) @(posedge i_mclk);
    `CHK({stby, rdy, write_enable_latch}, 3'b100)
    foreach (rows[k])
    begin
      i_host.xfer(rows[k].d, rows[k].n, rx, oe);
      `CHK({write_enable_latch, oe}, {rows[k].write_enable_latch, 1'b0})
    end
    `CHK(starts, 0)
    i_host.xfer(32'h06, 8, rx, oe);
    i_host.xfer(32'h0212345A, 32, rx, oe);
    `CHK({addr, data, busy}, {16'h1234, 8'h5A, 1'b1})
    `CHK(starts, 1)
    i_host.xfer(32'h04, 8, rx, oe);
    `CHK(write_enable_latch, 1'b1)
    i_host.xfer(32'h0500, 16, rx, oe);
    `CHK({rx, oe, busy}, {8'h03, 1'b1, 1'b1})
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge i_mclk);
    repeat (2) @(posedge i_mclk);
    `CHK({busy, write_enable_latch, stby}, 3'b001)
    `CHK(starts, 1)
    i_host.xfer(32'h06, 8, rx, oe);
    i_supply_ok <= 1'b0;
    repeat (6) @(posedge i_mclk);
    `CHK({write_enable_latch, stby}, 2'b00)
    i_supply_ok <= 1'b1;
    for (i = 0; i < 40 && stby !== 1'b1; i++) @(posedge i_mclk);
    `CHK({write_enable_latch, stby}, 2'b01)
    summarize();
  end
endmodule : test_eeprom_write_state
